/* shared/nv_access_pkg.sv */
/*
 Package for the host non-volatile memory access control block: register offset,
 field positions, reset value, command codes and arbiter grant encoding.
 Assumes a single 125 MHz host clock domain with synchronous active-high reset.
*/
package nv_access_pkg;
  localparam logic [7:0] reset_and_nv_access_control_offset = 8'h3c;
  localparam logic [31:0] reset_and_nv_access_control_reset = 32'h0000_0000;
  localparam int nv_enable_ready_pos = 31;
  localparam int nv_op_select_high_pos = 30;
  localparam int nv_op_select_low_pos = 29;
  localparam int nv_failed_pos = 28;
  localparam int mbox_flag_reset_pos = 27;
  localparam int read_fifo_reset_pos = 25;
  localparam int local_reset_pos = 24;
  localparam int nv_port_lsb = 16;
  localparam int nv_port_msb = 23;
  localparam logic [1:0] op_load_low = 2'h0;
  localparam logic [1:0] op_load_high = 2'h1;
  localparam logic [1:0] op_begin_write = 2'h2;
  localparam logic [1:0] op_begin_read = 2'h3;
  typedef enum logic [1:0] {grant_none, grant_host, grant_local} grant_e;
endpackage

/* logic/nv_arbiter.sv */
/*
 Two-requester arbiter for the shared external non-volatile memory port.
 Assumes requesters hold their request until granted; a grant then stays until done is seen.
*/
module nv_arbiter
  import nv_access_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic host_req_i,
  input wire logic local_req_i,
  input wire logic done_i,
  output nv_access_pkg::grant_e grant_o
);
  import nv_access_pkg::*;
  grant_e grant;
  logic last_host;
  wire idle = (grant == grant_none);
  // alternate priority when both request together so neither side starves
  wire pick_host = host_req_i && (!local_req_i || !last_host);
  assign grant_o = grant;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      grant <= grant_none;
      last_host <= 1'b0;
    end else if (idle) begin
      if (pick_host) begin
        grant <= grant_host; // [R7]
        last_host <= 1'b1;
      end else if (local_req_i) begin
        grant <= grant_local; // [R7]
        last_host <= 1'b0;
      end
    end else if (done_i) begin
      grant <= grant_none;
    end
  end

  a_arb_exclusive: assert property ( // [R7]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (grant != grant_none && !done_i) |=> $stable(grant))
    else $error("grant changed during a memory transaction");
endmodule

/* logic/host_nv_memory_access_control.sv */
/*
 Host-side reset and non-volatile memory access control register with the
 indirect byte port to the external memory and the shared-memory arbiter.
 Assumes a memory engine outside that takes one granted command (address,
 data, write/read) and returns a done pulse with read data and a fail flag.
*/
// Functional notes
// R1: one 32-bit control register at offset 3c carries local reset, mailbox and fifo resets and nv access.
// R2: bits 31..29 form the access-control field that commands external memory accesses.
// R3: software loads low address, then high address, then data through the 8-bit port field.
// R4: bit 31 is written one to start an access and reads one while busy, zero when ready.
// R5: software waits for bit 31 to read zero before the next access.
// R6: enable zero does nothing; with enable one the select codes load low, load high, write, read.
// R7: host and local requests to the memory are arbitrated so they never collide.
// R8: software on both sides coordinates use of the shared memory contents.
// R9: bits 23..16 carry address or write data and return the fetched byte after a read.
// R10: bit 28 flags a failed last access and clears when the next read or write starts.
// R11: bit 31 stays set from begin-write or begin-read until the memory transaction completes.
module host_nv_memory_access_control
  import nv_access_pkg::*;
#(
  parameter int addr_width = 16
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic local_req_i,
  output logic local_grant_o,
  output logic nv_start_o,
  output logic nv_write_o,
  output logic [addr_width-1:0] nv_addr_o,
  output logic [7:0] nv_wdata_o,
  input wire logic nv_done_i,
  input wire logic nv_fail_i,
  input wire logic [7:0] nv_rdata_i,
  output logic local_reset_o,
  output logic mbox_flag_reset_o,
  output logic read_fifo_reset_o
);
  import nv_access_pkg::*;

  logic busy;
  logic pending_write;
  logic failed;
  logic launched;
  logic [7:0] port_byte;
  logic [7:0] addr_low;
  logic [7:0] addr_high;
  logic local_reset;
  logic mbox_pulse;
  logic fifo_pulse;
  grant_e grant;

  // [R1] register decode
  wire sel = (reg_addr_i == reset_and_nv_access_control_offset);
  wire wr = sel && reg_wr_i;
  wire [1:0] op = {reg_wdata_i[nv_op_select_high_pos], reg_wdata_i[nv_op_select_low_pos]};
  // busy blocks further commands; software must poll first anyway
  wire cmd = wr && reg_wdata_i[nv_enable_ready_pos] && !busy; // [R6] [R5]
  wire [7:0] wbyte = reg_wdata_i[nv_port_msb:nv_port_lsb];
  wire start_op = cmd && (op == op_begin_write || op == op_begin_read); // [R2]
  wire host_granted = (grant == grant_host);
  wire host_done = host_granted && nv_done_i;
  wire [15:0] full_addr = {addr_high, addr_low};

  nv_arbiter u_arbiter (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .host_req_i(busy && !launched),
    .local_req_i(local_req_i),
    .done_i(nv_done_i),
    .grant_o(grant)
  );

  assign local_grant_o = (grant == grant_local); // [R7]
  assign nv_start_o = host_granted && busy && !launched;
  assign nv_write_o = pending_write;
  assign nv_addr_o = full_addr[addr_width-1:0];
  assign nv_wdata_o = port_byte;
  assign local_reset_o = local_reset;
  assign mbox_flag_reset_o = mbox_pulse;
  assign read_fifo_reset_o = fifo_pulse;

  // reserved bits and write-only pulse bits read as zero
  always_comb begin
    reg_rdata_o = 32'h0000_0000;
    if (sel && reg_rd_i) begin
      reg_rdata_o[nv_enable_ready_pos] = busy; // [R4]
      reg_rdata_o[nv_failed_pos] = failed; // [R10]
      reg_rdata_o[local_reset_pos] = local_reset;
      reg_rdata_o[nv_port_msb:nv_port_lsb] = port_byte; // [R9]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      local_reset <= 1'b0;
      mbox_pulse <= 1'b0;
      fifo_pulse <= 1'b0;
    end else begin
      mbox_pulse <= wr && reg_wdata_i[mbox_flag_reset_pos];
      fifo_pulse <= wr && reg_wdata_i[read_fifo_reset_pos];
      if (wr) begin
        local_reset <= reg_wdata_i[local_reset_pos];
      end
    end
  end

  // [R3] address and data bytes loaded in sequence through the port field
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      addr_low <= 8'h00;
      addr_high <= 8'h00;
      port_byte <= 8'h00;
    end else if (cmd && op == op_load_low) begin
      addr_low <= wbyte;
      port_byte <= wbyte;
    end else if (cmd && op == op_load_high) begin
      addr_high <= wbyte;
      port_byte <= wbyte;
    end else if (cmd && op == op_begin_write) begin
      port_byte <= wbyte; // [R9]
    end else if (host_done && !pending_write) begin
      port_byte <= nv_rdata_i; // [R9]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy <= 1'b0;
      launched <= 1'b0;
      pending_write <= 1'b0;
      failed <= 1'b0;
    end else begin
      if (start_op) begin
        busy <= 1'b1; // [R11]
        launched <= 1'b0;
        pending_write <= (op == op_begin_write);
        failed <= 1'b0; // [R10]
      end else if (host_done) begin
        busy <= 1'b0; // [R11]
        launched <= 1'b0;
        failed <= nv_fail_i; // [R10]
      end else if (nv_start_o) begin
        launched <= 1'b1;
      end
    end
  end

  sequence s_begin;
    start_op;
  endsequence

  // a command landing while busy must leave address and direction alone
  sequence s_cmd_while_busy;
    wr && reg_wdata_i[nv_enable_ready_pos] && busy;
  endsequence

  sequence s_write_begin;
    cmd && op == op_begin_write;
  endsequence

  a_busy_follows_start: assert property ( // [R11]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_begin |=> busy && !failed)
    else $error("busy or failed wrong after begin");
  a_busy_holds: assert property ( // [R11]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (busy && !host_done) |=> busy)
    else $error("busy dropped before completion");
  a_ready_after_done: assert property ( // [R4]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    host_done |=> !busy && (failed == $past(nv_fail_i)))
    else $error("ready or failed flag wrong after done");
  a_inactive_write: assert property ( // [R6]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wr && !reg_wdata_i[nv_enable_ready_pos] && !busy) |=> !busy && $stable(addr_low))
    else $error("enable-zero write had an effect");
  a_busy_ignores_cmd: assert property ( // [R6]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_cmd_while_busy |=> $stable(addr_low) && $stable(addr_high) && $stable(pending_write))
    else $error("command accepted while busy");
  a_load_low: assert property ( // [R3]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd && op == op_load_low) |=> addr_low == $past(wbyte) && !busy)
    else $error("low address not loaded");
  a_load_high: assert property ( // [R3]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd && op == op_load_high) |=> addr_high == $past(wbyte) && !busy)
    else $error("high address not loaded");
  a_write_latch: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_write_begin |=> pending_write && port_byte == $past(wbyte))
    else $error("write byte or direction not latched");
  a_read_byte: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (host_done && !pending_write) |=> port_byte == $past(nv_rdata_i))
    else $error("read byte not returned in port field");
  // failed may only move at a begin or at the end of a host access
  a_failed_steady: assert property ( // [R10]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (!start_op && !host_done) |=> $stable(failed))
    else $error("failed flag moved without an access");
  a_busy_readback: assert property ( // [R4]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (sel && reg_rd_i) |-> reg_rdata_o[nv_enable_ready_pos] == busy)
    else $error("enable/ready readback wrong");
  a_no_double_grant: assert property ( // [R7]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !(nv_start_o && local_grant_o))
    else $error("host start while local holds memory");
  a_start_once: assert property ( // [R2]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    nv_start_o |=> !nv_start_o)
    else $error("start pulse longer than one cycle");
endmodule

/* verification/nv_engine_model.sv */
/* memory engine model behind the nv port.
 assumes one clock, start and grant held per the arbiter. */
module nv_engine_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic grant_i,
  input wire logic req_i,
  input wire logic [15:0] addr_i,
  input wire logic fail_mode_i,
  input wire logic [3:0] delay_i,
  output logic done_o,
  output logic fail_o,
  output logic [7:0] rdata_o,
  output logic clash_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy, hold, host_op;
  logic [3:0] cnt;
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      {busy, hold, host_op, done_o, fail_o, clash_o} <= 6'h00;
      cnt <= 4'h0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      hold <= done_o;
      // outside done the answer lines toggle, so nothing stale passes
      fail_o <= ~fail_o;
      rdata_o <= ~rdata_o;
      if (busy && (start_i || (host_op && grant_i))) clash_o <= 1'b1;
      if (!busy && !hold && !done_o && (start_i || (grant_i && req_i))) begin
        busy <= 1'b1;
        cnt <= delay_i;
        host_op <= start_i;
      end else if (busy && cnt != 4'h0) cnt <= cnt - 4'h1;
      else if (busy) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        fail_o <= fail_mode_i;
        rdata_o <= addr_i[7:0] ^ addr_i[15:8] ^ 8'ha5;
      end
    end
  end
endmodule

/* verification/tb.sv */
/* self-checking bench for the nv access control register.
 assumes the engine model answers host and local requests. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nv_access_pkg::*;
  logic clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, local_req_i, local_grant_o, nv_start_o;
  logic nv_write_o, nv_done_i, nv_fail_i, local_reset_o, mbox_flag_reset_o, read_fifo_reset_o;
  logic fail_mode, clash;
  logic [7:0] reg_addr_i, nv_wdata_o, nv_rdata_i, b;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic [15:0] nv_addr_o, seed, a;
  logic [3:0] delay;
  int failures, n_tests, raised, served, i, k;
  host_nv_memory_access_control host_nv_memory_access_control_inst (.clk_sys_i, .sys_rst_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .local_req_i, .local_grant_o,
    .nv_start_o, .nv_write_o, .nv_addr_o, .nv_wdata_o, .nv_done_i, .nv_fail_i, .nv_rdata_i,
    .local_reset_o, .mbox_flag_reset_o, .read_fifo_reset_o);
  nv_engine_model nv_engine_model_inst (.clk_sys_i, .sys_rst_i, .start_i(nv_start_o),
    .grant_i(local_grant_o), .req_i(local_req_i), .addr_i(nv_addr_o), .fail_mode_i(fail_mode),
    .delay_i(delay), .done_o(nv_done_i), .fail_o(nv_fail_i), .rdata_o(nv_rdata_i), .clash_o(clash));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'ha5;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(negedge clk_sys_i);
    reg_addr_i = ad;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(negedge clk_sys_i);
    reg_addr_i = ad;
    reg_rd_i = 1'b1;
    @(posedge clk_sys_i);
    d = reg_rdata_o;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
  endtask
  task automatic op(input logic [1:0] c, input logic [7:0] v);
    wr(reset_and_nv_access_control_offset, {1'b1, c, 5'h00, v, 16'h0000});
  endtask
  task automatic poll;
    k = 0;
    do begin
      rd(reset_and_nv_access_control_offset);
      k++;
    end while (d[31] !== 1'b0 && k < 400);
    chk(d[31], 1'b0, "access never finished");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // local side drops its request once its transaction is answered
  always @(negedge clk_sys_i) begin
    if (local_req_i && local_grant_o && nv_done_i) begin
      local_req_i = 1'b0;
      served++;
    end
  end
  initial begin
    #200000;
    failures++;
    end_of_test;
  end
  initial begin
    {reg_wr_i, reg_rd_i, local_req_i, fail_mode} = 4'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    delay = 4'h4;
    seed = 16'h10d7;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i) sys_rst_i = 1'b0;
    rd(reset_and_nv_access_control_offset);
    chk(d, reset_and_nv_access_control_reset, "reset value");
    wr(8'h40, 32'h8100_0000);
    rd(8'h40);
    chk(d, 32'h0, "unmapped read");
    chk(local_reset_o, 1'b0, "unmapped write ignored");
    wr(reset_and_nv_access_control_offset, 32'h0aab_0000);
    chk({mbox_flag_reset_o, read_fifo_reset_o, local_reset_o}, 3'h6, "reset pulses");
    rd(reset_and_nv_access_control_offset);
    chk(d, 32'h0, "inactive write changed state");
    wr(reset_and_nv_access_control_offset, 32'h0100_0000);
    rd(reset_and_nv_access_control_offset);
    chk(d, 32'h0100_0000, "local reset bit");
    chk(local_reset_o, 1'b1, "local reset pin");
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = seed;
      seed = lfsr(seed);
      b = seed[7:0];
      delay = {1'b0, seed[10:8]} + 4'h4;
      if (i % 2 == 1 && !local_req_i) begin
        local_req_i = 1'b1;
        raised++;
      end
      op(op_load_low, a[7:0]);
      op(op_load_high, a[15:8]);
      op(op_begin_write, b);
      rd(reset_and_nv_access_control_offset);
      chk(d[31:28], 4'h8, "busy after begin, failed cleared");
      op(op_load_low, ~a[7:0]);
      poll;
      chk({nv_addr_o, nv_wdata_o, nv_write_o}, {a, b, 1'b1}, "write command");
      fail_mode = (i == 3 || i == 6);
      op(op_begin_read, 8'h00);
      poll;
      chk(d[28:16], {fail_mode, 4'h0, exp_rd(a)}, "read byte, failed");
      chk(nv_write_o, 1'b0, "read direction");
      fail_mode = 1'b0;
    end
    repeat (40) @(negedge clk_sys_i);
    chk(served, raised, "local requests served");
    chk(clash, 1'b0, "overlapping memory use");
    end_of_test;
  end
endmodule
